// *** asw_ctrl.sv ***
`timescale 1ns/1ps
// Summary of operation
// - Mode codes pick quad, dual or single
// - Code 11 mode field ignored, old mode kept
// - Quad: low two bits pick source
// - Dual: bit2 picks A/C or B/D pair
// - Single: four bits pick one channel
// - Enable bit zero drops all terminations
// - Pulse bit set: drop 100 ms on switch
// - Pulse bit clear: termination stays connected
// - Pulse bits map B, A, C reversed, D reversed
// - Switch disabled: no aux crosspoint closed
module asw_ctrl
  import asw_pkg::*;
#(
  parameter longint P_TERM_OFF_CYC = ASW_TERM_OFF_CYC // Drop time in cycles
)
(
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  // Register port
  input  wire logic        i_reg_wr,
  input  wire logic [1:0]  i_reg_addr,
  input  wire logic [7:0]  i_reg_wdata,
  output logic      [7:0]  o_reg_rdata,
  // High speed source change strobe
  input  wire logic        i_src_switch,
  // Low speed crosspoint
  output logic      [63:0] o_lowspeed_common_port,
  // Input terminations, one per channel in pulse-vector order
  output logic      [15:0] o_term_connect,
  output logic             o_term_pulse_busy
);

  // ========================================================================
  // Declarations
  localparam int TW = $clog2(P_TERM_OFF_CYC + 1); // Timer width
  localparam logic [TW-1:0] TERM_LOAD = TW'(P_TERM_OFF_CYC - 1);

  logic          aux_en_q;              // Low speed switch enable
  logic [1:0]    lowspeed_mode_sel_q;   // Held mode code
  logic [3:0]    lowspeed_source_sel_q; // Held source select
  logic          input_term_enable_q;   // Global termination enable
  logic [15:0]   term_pulse_on_switch_q;// Per-channel pulse select
  logic [TW-1:0] tmr_q;                 // Remaining drop cycles
  logic          busy_q;                // Drop window active
  logic [7:0]    rdata_d;               // Read mux

  // ========================================================================
  // Mode register; the illegal mode code leaves the held mode untouched
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aux_en_q              <= ASW_RST_AUX_EN;
      lowspeed_mode_sel_q   <= ASW_RST_MODE;
      lowspeed_source_sel_q <= ASW_RST_SRC;
    end else if (i_reg_wr && i_reg_addr == ASW_REG_AUX_MODE) begin
      aux_en_q              <= i_reg_wdata[ASW_AUX_EN_BIT];
      lowspeed_source_sel_q <= i_reg_wdata[ASW_SRC_LSB +: 4];
      // Other fields of the same write still land
      if (i_reg_wdata[ASW_MODE_LSB +: 2] != ASW_MODE_ILLEGAL) begin
        lowspeed_mode_sel_q <= i_reg_wdata[ASW_MODE_LSB +: 2];
      end
    end
  end

  // ========================================================================
  // Receiver and pulse registers
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      input_term_enable_q    <= ASW_RST_TERM_EN;
      term_pulse_on_switch_q <= {ASW_RST_PULSE, ASW_RST_PULSE};
    end else if (i_reg_wr) begin
      unique case (i_reg_addr)
        ASW_REG_RX_SET: begin
          input_term_enable_q <= i_reg_wdata[ASW_TERM_EN_BIT];
        end
        // Register 1 holds B0..B3 then A0..A3
        ASW_REG_TERM_PULSE1: begin
          term_pulse_on_switch_q[7:0] <= i_reg_wdata;
        end
        // Register 2 holds C3..C0 then D3..D0
        ASW_REG_TERM_PULSE2: begin
          term_pulse_on_switch_q[15:8] <= i_reg_wdata;
        end
        ASW_REG_AUX_MODE: begin
          // Handled by the mode register process
        end
      endcase
    end
  end

  // ========================================================================
  // Read mux, registered so read data never glitch with the address
  always_comb begin
    unique case (i_reg_addr)
      ASW_REG_AUX_MODE:    rdata_d = {1'b0, aux_en_q, lowspeed_mode_sel_q, lowspeed_source_sel_q};
      ASW_REG_RX_SET:      rdata_d = {7'h00, input_term_enable_q};
      ASW_REG_TERM_PULSE1: rdata_d = term_pulse_on_switch_q[7:0];
      ASW_REG_TERM_PULSE2: rdata_d = term_pulse_on_switch_q[15:8];
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reg_rdata <= 8'h00;
    end else begin
      o_reg_rdata <= rdata_d;
    end
  end

  // ========================================================================
  // Drop timer; one shared counter since every pulsed channel drops together
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tmr_q  <= '0;
      busy_q <= 1'b0;
    end else if (i_src_switch) begin
      // A new switch restarts the full window
      tmr_q  <= TERM_LOAD;
      busy_q <= 1'b1;
    end else if (busy_q) begin
      if (tmr_q == '0) begin
        busy_q <= 1'b0; // Window over, reconnect
      end else begin
        tmr_q <= tmr_q - TW'(1);
      end
    end
  end

  assign o_term_pulse_busy = busy_q;

  // ========================================================================
  // Termination drive: global enable, then per-channel pulse gating
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_term_connect <= 16'h0000;
    end else if (!input_term_enable_q) begin
      o_term_connect <= 16'h0000;
    end else begin
      // Unpulsed channels stay connected through a switch
      o_term_connect <= ~(term_pulse_on_switch_q & {16{busy_q}});
    end
  end

  // ========================================================================
  // Low speed crosspoint
  asw_xpt_decode u_xpt (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_enable  (aux_en_q),
    .i_mode    (lowspeed_mode_sel_q),
    .i_src     (lowspeed_source_sel_q),
    .o_xpt     (o_lowspeed_common_port)
  );

  // ========================================================================
  // Checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  a_mode_never_ill: assert property (lowspeed_mode_sel_q != ASW_MODE_ILLEGAL)
    else $error("illegal mode held");
  a_ill_write_kept: assert property (i_reg_wr && i_reg_addr == ASW_REG_AUX_MODE
      && i_reg_wdata[5:4] == ASW_MODE_ILLEGAL |=> $stable(lowspeed_mode_sel_q))
    else $error("illegal mode write changed mode");
  a_term_off_all: assert property (!input_term_enable_q |=> o_term_connect == 16'h0000)
    else $error("termination on while disabled");
  a_pulse_drop: assert property (input_term_enable_q && i_src_switch && !i_reg_wr
      |=> ##1 (o_term_connect == ~term_pulse_on_switch_q))
    else $error("pulsed channels not dropped");
  a_unpulsed_keep: assert property (input_term_enable_q && !i_reg_wr
      |=> ((o_term_connect | term_pulse_on_switch_q) == 16'hFFFF || !input_term_enable_q))
    else $error("unpulsed channel dropped");
  a_timer_restart: assert property (i_src_switch |=> busy_q && tmr_q == TERM_LOAD)
    else $error("timer not restarted");
  a_xpt_off: assert property (!aux_en_q |=> o_lowspeed_common_port == 64'h0)
    else $error("crosspoint closed while disabled");
  a_single_one: assert property (aux_en_q && lowspeed_mode_sel_q == ASW_MODE_SINGLE
      |=> o_lowspeed_common_port == 64'h1 << $past(lowspeed_source_sel_q))
    else $error("single mode route wrong");
  a_quad_four: assert property (aux_en_q && lowspeed_mode_sel_q == ASW_MODE_QUAD
      |=> $countones(o_lowspeed_common_port) == 4)
    else $error("quad mode route count wrong");
  a_dual_two: assert property (aux_en_q && lowspeed_mode_sel_q == ASW_MODE_DUAL
      |=> $countones(o_lowspeed_common_port) == 2)
    else $error("dual mode route count wrong");

endmodule // asw_ctrl

// *** asw_pkg.sv ***
// ==========================================================================
// Shared constants of the low speed switch and termination control
package asw_pkg;
  // ========================================================================
  // Register indices on the local register port
  localparam logic [1:0] ASW_REG_AUX_MODE    = 2'h0; // aux_mode_control
  localparam logic [1:0] ASW_REG_RX_SET      = 2'h1; // receiver_settings
  localparam logic [1:0] ASW_REG_TERM_PULSE1 = 2'h2; // term_pulse_select_1
  localparam logic [1:0] ASW_REG_TERM_PULSE2 = 2'h3; // term_pulse_select_2

  // ========================================================================
  // Field positions
  localparam int ASW_AUX_EN_BIT   = 6; // Low speed switch enable
  localparam int ASW_MODE_LSB     = 4; // lowspeed_mode_sel at bits 5:4
  localparam int ASW_SRC_LSB      = 0; // lowspeed_source_sel at bits 3:0
  localparam int ASW_TERM_EN_BIT  = 0; // input_term_enable

  // ========================================================================
  // Switching mode codes
  localparam logic [1:0] ASW_MODE_QUAD    = 2'h0; // Four 4:1 switches
  localparam logic [1:0] ASW_MODE_DUAL    = 2'h1; // Two 8:1 switches
  localparam logic [1:0] ASW_MODE_SINGLE  = 2'h2; // One 16:1 switch
  localparam logic [1:0] ASW_MODE_ILLEGAL = 2'h3; // Rejected on write

  // ========================================================================
  // Reset values (match the strapped defaults of the control pins)
  localparam logic       ASW_RST_AUX_EN  = 1'b1;
  localparam logic [1:0] ASW_RST_MODE    = 2'h0;
  localparam logic [3:0] ASW_RST_SRC     = 4'h0;
  localparam logic       ASW_RST_TERM_EN = 1'b1;
  localparam logic [7:0] ASW_RST_PULSE   = 8'h00;

  // ========================================================================
  // Timing
  localparam longint ASW_CLK_HZ     = 40_000_000; // System clock rate
  localparam longint ASW_TERM_OFF_MS = 100;       // Termination drop time
  localparam longint ASW_TERM_OFF_CYC = (ASW_TERM_OFF_MS * ASW_CLK_HZ) / 1000;
endpackage : asw_pkg

// *** asw_xpt_decode.sv ***
`timescale 1ns/1ps
// ==========================================================================
// Crosspoint decoder: bit [line*16 + source*4 + channel] closes a switch
module asw_xpt_decode
  import asw_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  // Settings
  input  wire logic        i_enable,
  input  wire logic [1:0]  i_mode,
  input  wire logic [3:0]  i_src,
  // Crosspoint matrix
  output logic      [63:0] o_xpt
);

  // ========================================================================
  // Decode function, kept pure so the matrix is one flop stage deep
  function automatic logic [63:0] xpt_decode(input logic en, input logic [1:0] mode, input logic [3:0] src);
    logic [63:0] m;
    m = '0;
    if (en) begin
      unique case (mode)
        ASW_MODE_QUAD: begin
          // Each line k takes channel k of the source in bits 1:0
          for (int k = 0; k < 4; k++) begin
            m[k*16 + src[1:0]*4 + k] = 1'b1;
          end
        end
        ASW_MODE_DUAL: begin
          // Bit 3 unused; bit 2 picks A/C versus B/D
          m[0*16 + {2'b00, src[2]}*4 + src[1:0]]  = 1'b1;
          m[2*16 + {2'b01, src[2]}*4 + src[1:0]]  = 1'b1;
        end
        ASW_MODE_SINGLE: begin
          m[src] = 1'b1;
        end
        default: begin
          m = '0; // Never held, since writes of the illegal code are dropped
        end
      endcase
    end
    return m;
  endfunction

  // ========================================================================
  // Registered matrix output
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_xpt <= 64'h0;
    end else begin
      o_xpt <= xpt_decode(i_enable, i_mode, i_src);
    end
  end

endmodule // asw_xpt_decode

// *** aux_switch_and_termination_control_tb.sv ***
`timescale 1ns/1ps
module aux_switch_and_termination_control_tb
  import asw_pkg::*;
;
  // ========================================================================
  // Signals and state
  localparam int P_CYC = 20;           // Short drop window keeps the run brief
  typedef struct {logic [7:0] wdata; logic [7:0] rdata; logic [63:0] xpt;} asw_row_type;
  logic        i_clk_sys   = 1'b0;
  logic        i_rst_n     = 1'b0;
  logic        i_reg_wr    = 1'b0;
  logic [1:0]  i_reg_addr  = 2'h0;
  logic [7:0]  i_reg_wdata = 8'h00;
  logic        i_src_switch = 1'b0;
  logic [7:0]  o_reg_rdata;
  logic [63:0] o_lowspeed_common_port;
  logic [15:0] o_term_connect;
  logic        o_term_pulse_busy;
  int          mismatches = 0;         // Failed comparisons
  int          compares   = 0;         // All comparisons
  int          cycles     = 0;         // Hang guard
  asw_row_type rows [10];              // Mode register write, readback, crosspoint

  asw_ctrl #(.P_TERM_OFF_CYC(P_CYC)) i_dut (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .i_src_switch(i_src_switch),
    .o_lowspeed_common_port(o_lowspeed_common_port), .o_term_connect(o_term_connect),
    .o_term_pulse_busy(o_term_pulse_busy));

  // ========================================================================
  // Clock and hang guard; the ceiling is far above the expected run
  initial begin
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches = mismatches + 1;
      stop_test();
    end
  end

  // ========================================================================
  // Shared tasks
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Inputs change on the falling edge, so the rising edge sees them settled
  task automatic reg_write(input logic [1:0] addr, input logic [7:0] data);
    @(negedge i_clk_sys);
    i_reg_wr = 1'b1;
    i_reg_addr = addr;
    i_reg_wdata = data;
    @(negedge i_clk_sys);
    i_reg_wr = 1'b0;
    repeat (2) @(negedge i_clk_sys);
  endtask
  task automatic strobe();
    @(negedge i_clk_sys);
    i_src_switch = 1'b1;
    @(negedge i_clk_sys);
    i_src_switch = 1'b0;
  endtask
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ========================================================================
  // Main sequence
  initial begin
    // Mode rows: quad, quad with high bits, dual both halves, single, illegal, off
    rows[0] = '{8'h43, 8'h43, 64'h8000_4000_2000_1000};
    rows[1] = '{8'h4E, 8'h4E, 64'h0800_0400_0200_0100};
    rows[2] = '{8'h5A, 8'h5A, 64'h0000_0400_0000_0004};
    rows[3] = '{8'h57, 8'h57, 64'h0000_8000_0000_0080};
    rows[4] = '{8'h56, 8'h56, 64'h0000_4000_0000_0040}; // Dual, bit 2 set: B2 and D2
    rows[5] = '{8'h60, 8'h60, 64'h0000_0000_0000_0001};
    rows[6] = '{8'h6F, 8'h6F, 64'h0000_0000_0000_8000};
    rows[7] = '{8'h69, 8'h69, 64'h0000_0000_0000_0200};
    rows[8] = '{8'h71, 8'h61, 64'h0000_0000_0000_0002};
    rows[9] = '{8'h05, 8'h05, 64'h0000_0000_0000_0000};
    repeat (16) @(negedge i_clk_sys);
    check("rdata in reset", o_reg_rdata, 64'h0);
    check("xpt in reset", o_lowspeed_common_port, 64'h0);
    check("term in reset", o_term_connect, 64'h0);
    i_rst_n = 1'b1;
    repeat (3) @(negedge i_clk_sys);
    check("mode reset value", o_reg_rdata, 64'h40);
    check("xpt after reset", o_lowspeed_common_port, 64'h0008_0004_0002_0001);
    check("term after reset", o_term_connect, 64'hFFFF);
    $display("Test done: reset");
    for (int k = 0; k < 10; k++) begin
      reg_write(ASW_REG_AUX_MODE, rows[k].wdata);
      check("mode readback", o_reg_rdata, rows[k].rdata);
      check("crosspoint", o_lowspeed_common_port, rows[k].xpt);
    end
    $display("Test done: mode table");
    // Pulse vector halves and receiver bit; unused receiver bits read zero
    reg_write(ASW_REG_RX_SET, 8'hFF);
    check("receiver readback", o_reg_rdata, 64'h01);
    reg_write(ASW_REG_TERM_PULSE1, 8'h5A);
    reg_write(ASW_REG_TERM_PULSE2, 8'hC3);
    check("pulse2 readback", o_reg_rdata, 64'hC3);
    strobe();
    @(negedge i_clk_sys);
    check("busy in window", o_term_pulse_busy, 64'h1);
    check("term dropped", o_term_connect, 64'h3CA5);
    repeat (10) @(negedge i_clk_sys);
    strobe();
    repeat (14) @(negedge i_clk_sys);
    check("term after restart", o_term_connect, 64'h3CA5);
    repeat (P_CYC) @(negedge i_clk_sys);
    check("busy after window", o_term_pulse_busy, 64'h0);
    check("term reconnected", o_term_connect, 64'hFFFF);
    $display("Test done: termination pulse");
    // Global termination off overrides everything
    reg_write(ASW_REG_RX_SET, 8'h00);
    check("term disabled", o_term_connect, 64'h0000);
    reg_write(ASW_REG_RX_SET, 8'h01);
    reg_write(ASW_REG_TERM_PULSE1, 8'h00);
    reg_write(ASW_REG_TERM_PULSE2, 8'h00);
    strobe();
    repeat (2) @(negedge i_clk_sys);
    check("term kept", o_term_connect, 64'hFFFF);
    $display("Test done: termination enable");
    // Reset in mid-window returns everything to defaults
    strobe();
    i_rst_n = 1'b0;
    @(negedge i_clk_sys);
    check("busy cleared", o_term_pulse_busy, 64'h0);
    i_rst_n = 1'b1;
    repeat (3) @(negedge i_clk_sys);
    check("xpt after rereset", o_lowspeed_common_port, 64'h0008_0004_0002_0001);
    $display("Test done: second reset");
    stop_test();
  end
endmodule // aux_switch_and_termination_control_tb
